// file: askr_pkg.sv
// Package with constants for the keystroke serial receiver.
package askr_pkg;
  localparam logic [15:0] ASKR_RELOAD       = 16'h03d7;
  localparam logic [3:0]  ASKR_START_TICKS  = 4'h4;
  localparam logic [3:0]  ASKR_BIT_TICKS    = 4'h8;
  localparam logic [3:0]  ASKR_DATA_BITS    = 4'h8;
  localparam logic [7:0]  ASKR_FIRST_WEIGHT = 8'h80;
  localparam logic [7:0]  ASKR_ACC_CLEAR    = 8'h00;
  localparam int          ASKR_PRESCALE     = 2;
  typedef enum logic [1:0] {ASKR_IDLE, ASKR_START, ASKR_DATA, ASKR_STOP} askr_state_e;
endpackage : askr_pkg

// file: askr_receiver.sv
// Receive-only keystroke serial port with a reloaded one-eighth-bit timer.
//
// Behaviour
// [R1] Accept ten-bit asynchronous words at 1200 baud on one input line.
// [R2] Keyboard frames one start, eight data bits MSB first, one stop.
// [R3] Line idles high; a start bit is low.
// [R4] Timer counts clock divided by two, reload 03d7 hex, one-eighth bit.
// [R5] Reload loaded at reset, timer stopped until a start is seen.
// [R6] While idle a low line level is a possible start bit.
// [R7] On possible start ignore line, run timer, resample after four expiries.
// [R8] High mid-start sample is a glitch: stop, reload, re-arm.
// [R9] Sample each data bit once every eight expiries at mid-bit.
// [R10] High samples add weights 80 hex halving; accumulator starts at zero.
// [R11] After the last bit move byte to storage and clear accumulator.
// [R12] Store bytes at consecutive memory locations, pointer advancing each byte.
// [R13] Ignore line in stop bit; at its end stop, reload, re-arm.
// [R14] Sampling more than once per bit is recommended only.
// [R15] Pulse byte-valid one cycle with the completed byte.
// [R16] Synchronise the serial input before use.
`timescale 1ns/100ps
module askr_receiver
  import askr_pkg::*;
#(
  parameter int          ADDR_W = 8,
  parameter int          DEPTH  = 256,
  // Timer reload; the default gives one eighth of a bit per expiry.
  parameter logic [15:0] RELOAD = ASKR_RELOAD
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic              i_serial_in,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic      [7:0]        o_rd_data,
  output logic      [7:0]        o_byte,
  output logic                   o_byte_valid,
  output logic      [ADDR_W-1:0] o_wr_ptr,
  output logic                   o_busy
);

  logic [2:0]      sync_ff;
  logic            line_lvl;
  logic            prescale;
  logic            timer_run;
  logic [15:0]     timer_cnt;
  logic            expiry;
  logic [3:0]      tick_cnt;
  logic [3:0]      bit_idx;
  logic [7:0]      weight;
  logic [7:0]      acc;
  askr_state_e     state;
  logic [7:0]      mem [DEPTH];
  logic [7:0]      next_acc;
  logic            start_seen;
  logic            start_done;
  logic            start_ok;
  logic            glitch;
  logic            bit_done;
  logic            last_bit;
  logic            stop_done;

  // [R16] Input synchroniser.
  always_ff @(posedge i_core_clk) begin
    sync_ff <= {sync_ff[1:0], i_serial_in};
  end

  // The level changes only once the second and third stages agree.
  // Reset forces it high, so the unreset stages cannot start a false frame.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      line_lvl <= 1'b1;
    end else if (sync_ff[1] == sync_ff[2]) begin
      line_lvl <= sync_ff[2];
    end
  end

  // [R4] Divide by two prescaler and reload timer.
  // The prescaler restarts with the timer so every frame starts in phase.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !timer_run) begin
      prescale <= 1'b0;
    end else begin
      prescale <= ~prescale;
    end
  end

  // One expiry every 2 * (RELOAD + 1) clocks; eight of them make one bit time.
  assign expiry = timer_run && prescale && (timer_cnt == 16'h0000);

  // [R5] Timer loaded with the reload value while stopped.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !timer_run) begin
      timer_cnt <= RELOAD;
    end else if (prescale) begin
      timer_cnt <= (timer_cnt == 16'h0000) ? RELOAD : timer_cnt - 16'h0001;
    end
  end

  // Phase decodes shared by the processes below.
  assign start_seen = (state == ASKR_IDLE) && !line_lvl;
  assign start_done = (state == ASKR_START) && expiry && (tick_cnt + 4'h1 == ASKR_START_TICKS);
  assign start_ok   = start_done && !line_lvl;
  assign glitch     = start_done && line_lvl;
  // [R14] One sample per bit at mid-bit; the input filter rejects one-cycle spikes.
  assign bit_done   = (state == ASKR_DATA) && expiry && (tick_cnt + 4'h1 == ASKR_BIT_TICKS);
  assign last_bit   = bit_done && (bit_idx + 4'h1 == ASKR_DATA_BITS);
  // [R1] Ten bit times per word: rest of the last data bit plus the stop bit.
  assign stop_done  = (state == ASKR_STOP) && expiry
                      && (tick_cnt + 4'h1 == ASKR_BIT_TICKS + ASKR_START_TICKS);

  always_comb begin
    next_acc = acc;
    if (line_lvl) begin
      next_acc = acc + weight;
    end
  end

  // Frame sequencer; the line is watched every cycle in idle, otherwise only at the sample points.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= ASKR_IDLE;
    end else begin
      case (state)
        ASKR_IDLE: begin
          // [R6] Low level is a possible start.
          if (start_seen) begin
            state <= ASKR_START;
          end
        end
        ASKR_START: begin
          // [R7] Mid start-bit resample.
          if (glitch) begin
            // [R8] Glitch rejected.
            state <= ASKR_IDLE;
          end else if (start_ok) begin
            state <= ASKR_DATA;
          end
        end
        ASKR_DATA: begin
          // [R11] Stop bit follows the last data bit.
          if (last_bit) begin
            state <= ASKR_STOP;
          end
        end
        ASKR_STOP: begin
          // [R13] Line ignored until the stop bit ends.
          if (stop_done) begin
            state <= ASKR_IDLE;
          end
        end
        default: begin
          state <= ASKR_IDLE;
        end
      endcase
    end
  end

  // [R7] Timer started on a possible start.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      timer_run <= 1'b0;
      o_busy    <= 1'b0;
    end else if (start_seen) begin
      timer_run <= 1'b1;
      o_busy    <= 1'b1;
    end else if (glitch || stop_done) begin
      // [R8] Stopped on a glitch.
      // [R13] Stopped at the end of the stop bit.
      timer_run <= 1'b0;
      o_busy    <= 1'b0;
    end
  end

  // [R9] Each phase counts its own expiries from zero.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || start_seen || start_done || bit_done || stop_done) begin
      tick_cnt <= 4'h0;
    end else if (expiry) begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end

  // [R10] Weighted accumulation, most significant bit first.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || start_ok) begin
      bit_idx <= 4'h0;
      weight  <= ASKR_FIRST_WEIGHT;
      acc     <= ASKR_ACC_CLEAR;
    end else if (bit_done) begin
      bit_idx <= bit_idx + 4'h1;
      weight  <= weight >> 1;
      // [R11] Accumulator cleared once the byte is complete.
      acc     <= last_bit ? ASKR_ACC_CLEAR : next_acc;
    end
  end

  // [R15] Completed byte with a one-cycle strobe.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_byte       <= 8'h00;
      o_byte_valid <= 1'b0;
      o_wr_ptr     <= '0;
    end else begin
      o_byte_valid <= last_bit;
      if (last_bit) begin
        o_byte   <= next_acc;
        // [R12] Pointer advance.
        o_wr_ptr <= o_wr_ptr + 1'b1;
      end
    end
  end

  // [R12] Byte storage at consecutive locations.
  always_ff @(posedge i_core_clk) begin
    if (last_bit) begin
      mem[o_wr_ptr] <= next_acc;
    end
  end

  // Registered read port; entries never written read back as unknown.
  always_ff @(posedge i_core_clk) begin
    o_rd_data <= mem[i_rd_addr];
  end

endmodule : askr_receiver

// file: askr_receiver_monitor.sv
// Checker for the keystroke receiver ports.
`timescale 1ns/100ps
module askr_receiver_monitor #(parameter int ADDR_W = 8) (
  input wire logic              i_core_clk,
  input wire logic              i_srst,
  input wire logic              i_serial_in,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  input wire logic [7:0]        o_rd_data,
  input wire logic [7:0]        o_byte,
  input wire logic              o_byte_valid,
  input wire logic [ADDR_W-1:0] o_wr_ptr,
  input wire logic              o_busy
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_low_idle;
    (!o_busy && !i_serial_in)[*8];
  endsequence
  chk_start_seen: assert property (s_low_idle |=> o_busy) else $error("start missed");
  chk_start_hold: assert property ($rose(o_busy) |=> o_busy[*8]) else $error("busy short");
  chk_valid_once: assert property (o_byte_valid |=> !o_byte_valid) else $error("long strobe");
  chk_ptr_step: assert property (o_byte_valid |-> o_wr_ptr == $past(o_wr_ptr) + 1'b1) else $error("ptr");
  chk_ptr_hold: assert property (!o_byte_valid |-> $stable(o_wr_ptr)) else $error("ptr moved");
  chk_byte_hold: assert property (!o_byte_valid |-> $stable(o_byte)) else $error("byte moved");
  chk_valid_busy: assert property (o_byte_valid |-> o_busy) else $error("strobe idle");
  chk_stop_ignore: assert property (o_byte_valid |=> o_busy[*8]) else $error("stop cut");
endmodule : askr_receiver_monitor
bind askr_receiver askr_receiver_monitor #(.ADDR_W(ADDR_W)) i_mon (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_serial_in(i_serial_in), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_byte(o_byte),
  .o_byte_valid(o_byte_valid), .o_wr_ptr(o_wr_ptr), .o_busy(o_busy));

// file: askr_kbd_model.sv
// Keyboard model driving the serial line.
`timescale 1ns/100ps
module askr_kbd_model (
  input  wire logic i_core_clk,
  output logic      o_line
);
  initial o_line = 1'b1;
  // Frame bits sent from the top down.
  task automatic tx(input logic [9:0] f, input int n);
    for (int i = 9; i >= 0; i--) begin
      @(posedge i_core_clk) #1 o_line = f[i];
      repeat (n - 1) @(posedge i_core_clk);
    end
  endtask : tx
endmodule : askr_kbd_model

// file: askr_receiver_tb.sv
// Testbench for the keystroke serial receiver.
`timescale 1ns/100ps
module askr_receiver_tb;
  import askr_pkg::*;
  // A short reload keeps the run brief; the bit time scales with it.
  localparam logic [15:0] TB_RELOAD = 16'h0007;
  localparam int          BIT_CYC   = 8 * ASKR_PRESCALE * (int'(TB_RELOAD) + 1);
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       line;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data, byte_q, wr_ptr;
  logic       vld, busy;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         nv = 0;
  logic [7:0] sent[$];
  always #5 clk = ~clk;
  askr_kbd_model i_kbd (.i_core_clk(clk), .o_line(line));
  askr_receiver #(.RELOAD(TB_RELOAD)) i_dut (.i_core_clk(clk), .i_srst(srst), .i_serial_in(line),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_byte(byte_q), .o_byte_valid(vld), .o_wr_ptr(wr_ptr), .o_busy(busy));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic idle_wait();
    int k;
    for (k = 0; k < 4 * BIT_CYC && busy !== 1'b0; k++) @(posedge clk);
    if (k == 4 * BIT_CYC) begin
      n_errors++;
      tally_and_finish();
    end
    repeat (8) @(posedge clk);
  endtask : idle_wait
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    logic [7:0] acc;
    f = {1'b0, v, 1'b1};
    acc = ASKR_ACC_CLEAR;
    for (int k = 0; k < 8; k++) if (f[8-k]) acc += ASKR_FIRST_WEIGHT >> k;
    sent.push_back(acc);
    i_kbd.tx(f, BIT_CYC);
    idle_wait();
  endtask : send
  always @(negedge clk) if (vld === 1'b1) begin
    chk("byte", sent[nv], byte_q);
    chk("wr_ptr", 8'(nv + 1), wr_ptr);
    nv++;
  end
  initial begin
    void'($urandom(32'he643));
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    repeat (8) @(posedge clk);
    i_kbd.tx(10'h1ff, BIT_CYC / 4);
    idle_wait();
    chk("glitch_ptr", 8'h00, wr_ptr);
    send(8'h80);
    send(8'h01);
    repeat (4) send(8'($urandom));
    chk("count", 8'(sent.size()), wr_ptr);
    foreach (sent[i]) begin
      @(posedge clk) #1 rd_addr = 8'(i);
      @(posedge clk) #1 chk("mem", sent[i], rd_data);
    end
    tally_and_finish();
  end
endmodule : askr_receiver_tb
